// ==== hw/lpcp_pkg.sv ====
// lpcp_pkg: constants and types of the bus target
// assumes a 4-bit multiplexed frame-based host bus on its own clock
package lpcp_pkg;
  // nibble codes on the link
  localparam logic [3:0] NIB_START = 4'h0;
  localparam logic [3:0] SY_READY = 4'h0;
  localparam logic [3:0] SY_SHORT = 4'h5;
  localparam logic [3:0] SY_LONG = 4'h6;
  localparam logic [3:0] SY_ERR = 4'ha;
  localparam logic [3:0] NIB_TAR = 4'hf;
  // cycle type field, bits 3:1 of the nibble
  localparam logic [2:0] CT_IO_RD = 3'h0;
  localparam logic [2:0] CT_IO_WR = 3'h1;
  localparam logic [2:0] CT_DMA_RD = 3'h4;
  localparam logic [2:0] CT_DMA_WR = 3'h5;
  // size field: last byte index
  localparam logic [1:0] SZ_1 = 2'h0;
  localparam logic [1:0] SZ_2 = 2'h1;
  localparam logic [1:0] SZ_4 = 2'h3;
  // least wait syncs per cycle type
  localparam logic [8:0] WAIT_IO_RD = 9'h003;
  localparam logic [8:0] WAIT_IO_WR = 9'h002;
  localparam logic [8:0] WAIT_DMA_RD = 9'h003;
  localparam logic [8:0] WAIT_DMA_WR = 9'h004;
  // most syncs per byte
  localparam logic [8:0] SHORT_MAX = 9'h008;
  localparam int LINK_KHZ = 32'h0000_80e8;  // 33 MHz link clock
  localparam int TIMEOUT_US = 32'h0000_000a;
  localparam logic [8:0] LONG_MAX = 9'(TIMEOUT_US * LINK_KHZ / 32'h0000_03e8);
  localparam logic [2:0] LDRQ_BITS = 3'h5;
  localparam int NWIN = 32'h0000_0004;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CT, ST_ADDR, ST_CH, ST_SIZE, ST_HDATA,
    ST_HTAR, ST_SYNC, ST_DDATA, ST_DTAR, ST_IGN
  } lpcp_state_t;

  typedef struct packed {
    logic en;
    logic [15:0] base;
    logic [15:0] mask;  // set bits are not compared
  } lpcp_win_t;

  typedef struct packed {
    logic dma;
    logic wr;  // data flows host to device
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [2:0] chan;
    logic tc;
    logic [1:0] bidx;
  } lpcp_req_t;
endpackage

// ==== hw/lpcp_target.sv ====
// lpcp_target: device end of the 4-bit host bus, byte requests to user logic
// assumes lclk is the bus clock and clk runs the user side, phases unrelated
`timescale 1ns/1ns
module lpcp_target
  import lpcp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic lclk,
  input wire logic bus_reset_n,
  input wire logic cycle_frame_n,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe,
  output logic dma_request_line_n,
  input wire lpcp_win_t [NWIN-1:0] win,
  output logic usr_req_valid,
  output lpcp_req_t usr_req,
  input wire logic usr_ack,
  input wire logic [7:0] usr_rdata,
  input wire logic usr_err,
  input wire logic dma_rq_valid,
  input wire logic [2:0] dma_rq_chan,
  input wire logic dma_rq_act,
  output logic dma_rq_ready
);

  typedef struct packed {
    lpcp_state_t st;
    logic ce_s1;
    logic ce_s2;
    lpcp_win_t [NWIN-1:0] win_s1;
    lpcp_win_t [NWIN-1:0] win_s2;
    logic dma;
    logic wr;
    logic err;
    logic tc;
    logic [15:0] addr;
    logic [7:0] data;
    logic [2:0] chan;
    logic [1:0] size;
    logic [1:0] bidx;
    logic [1:0] nib;
    logic [8:0] wcnt;
    logic sent;
    logic adopted;
    logic [1:0] boot;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    lpcp_req_t rq;
    logic [3:0] lad_out;
    logic lad_oe;
    logic ldrq_n;
    logic dq_s1;
    logic dq_s2;
    logic dq_ack;
    logic [4:0] dq_sh;
    logic [2:0] dq_cnt;
  } lpcp_link_t;

  typedef struct packed {
    logic rq_s1;
    logic rq_s2;
    logic rq_s3;
    logic req_valid;
    logic pend;
    logic ack_tgl;
    logic err;
    lpcp_req_t req;
    logic [7:0] rdata;
    logic dq_tgl;
    logic dq_act;
    logic [2:0] dq_chan;
    logic dq_s1;
    logic dq_s2;
    logic dq_ready;
    logic ad_s1;
    logic ad_s2;
  } lpcp_sys_t;

  lpcp_link_t l_reg;
  lpcp_link_t l_next;
  lpcp_sys_t s_reg;
  lpcp_sys_t s_next;

  // bus reset also clears the link side; user reset too, to keep toggles paired
  logic lrst_n;
  assign lrst_n = bus_reset_n & resetn;

  assign lad_out = l_reg.lad_out;
  assign lad_oe = l_reg.lad_oe;
  assign dma_request_line_n = l_reg.ldrq_n;
  assign usr_req_valid = s_reg.req_valid;
  assign usr_req = s_reg.req;
  assign dma_rq_ready = s_reg.dq_ready;

  // address decode against the synchronised windows
  logic [15:0] addr_full;
  logic [NWIN-1:0] hit_v;
  assign addr_full = {l_reg.addr[11:0], lad_in};
  for (genvar i = 0; i < NWIN; i++) begin : g_win
    assign hit_v[i] = l_reg.win_s2[i].en &&
      (((addr_full ^ l_reg.win_s2[i].base) & ~l_reg.win_s2[i].mask) == 16'h0000);
  end

  // per-cycle wait policy
  logic [3:0] wcode;
  logic [8:0] minw;
  logic [8:0] smax;
  logic busy;
  logic more;
  always_comb begin
    wcode = l_reg.dma ? SY_SHORT : SY_LONG;
    if (l_reg.dma) begin
      minw = l_reg.wr ? WAIT_DMA_RD : WAIT_DMA_WR;
    end else begin
      minw = l_reg.wr ? WAIT_IO_WR : WAIT_IO_RD;
    end
    smax = l_reg.dma ? SHORT_MAX : LONG_MAX;
    busy = l_reg.req_tgl != l_reg.ack_s2;
    more = l_reg.dma && !l_reg.err && (l_reg.bidx != l_reg.size);
  end

  always_comb begin
    l_next = l_reg;
    l_next.ce_s1 = ce;
    l_next.ce_s2 = l_reg.ce_s1;
    l_next.win_s1 = win;
    l_next.win_s2 = l_reg.win_s1;
    l_next.ack_s1 = s_reg.ack_tgl;
    l_next.ack_s2 = l_reg.ack_s1;
    l_next.dq_s1 = s_reg.dq_tgl;
    l_next.dq_s2 = l_reg.dq_s1;
    // after reset take over the user side's toggle phase, once the
    // synchronisers hold real values again; a bus reset alone must not unpair them
    if (!l_reg.adopted) begin
      l_next.boot = l_reg.boot + 2'h1;
      l_next.adopted = l_reg.boot == 2'h3;
      if (l_reg.boot == 2'h2) begin
        l_next.req_tgl = l_reg.ack_s2;
        l_next.dq_ack = l_reg.dq_s2;
      end
    end else if (l_reg.ce_s2) begin
      if (l_reg.dq_cnt != 3'h0) begin
        l_next.ldrq_n = l_reg.dq_sh[4];
        l_next.dq_sh = {l_reg.dq_sh[3:0], 1'b1};
        l_next.dq_cnt = l_reg.dq_cnt - 3'h1;
      end else begin
        l_next.ldrq_n = 1'b1;
        if (l_reg.dq_s2 != l_reg.dq_ack) begin
          l_next.dq_sh = {1'b0, s_reg.dq_chan, s_reg.dq_act};
          l_next.dq_cnt = LDRQ_BITS;
          l_next.dq_ack = l_reg.dq_s2;
        end
      end
      if (!cycle_frame_n) begin
        l_next.lad_oe = 1'b0;
        l_next.st = (lad_in == NIB_START) ? ST_CT : ST_IDLE;
      end else begin
        unique case (l_reg.st)
          ST_IDLE, ST_IGN: begin
          end
          ST_CT: begin
            l_next.nib = 2'h0;
            l_next.bidx = 2'h0;
            l_next.err = 1'b0;
            l_next.dma = lad_in[3];
            l_next.wr = lad_in[3] ^ lad_in[1];
            unique case (lad_in[3:1])
              CT_IO_RD, CT_IO_WR: l_next.st = ST_ADDR;
              CT_DMA_RD, CT_DMA_WR: l_next.st = ST_CH;
              default: l_next.st = ST_IGN;
            endcase
          end
          ST_ADDR: begin
            l_next.addr = addr_full;
            l_next.nib = l_reg.nib + 2'h1;
            if (l_reg.nib == 2'h3) begin
              if (|hit_v) begin
                l_next.st = l_reg.wr ? ST_HDATA : ST_HTAR;
              end else begin
                l_next.st = ST_IGN;
              end
            end
          end
          ST_CH: begin
            l_next.chan = lad_in[2:0];
            l_next.tc = lad_in[3];
            l_next.st = ST_SIZE;
          end
          ST_SIZE: begin
            l_next.size = lad_in[1:0];
            unique case (lad_in[1:0])
              SZ_1, SZ_2, SZ_4: l_next.st = l_reg.wr ? ST_HDATA : ST_HTAR;
              default: l_next.st = ST_IGN;
            endcase
          end
          ST_HDATA: begin
            // one byte per io cycle, low nibble first
            if (l_reg.nib == 2'h0) begin
              l_next.data[3:0] = lad_in;
              l_next.nib = 2'h1;
            end else begin
              l_next.data[7:4] = lad_in;
              l_next.nib = 2'h0;
              l_next.st = ST_HTAR;
            end
          end
          ST_HTAR: begin
            l_next.nib = 2'h1;
            if (l_reg.nib == 2'h1) begin
              // first sync right after the host's turnaround
              l_next.lad_out = wcode;
              l_next.lad_oe = 1'b1;
              l_next.wcnt = 9'h001;
              l_next.sent = 1'b0;
              l_next.nib = 2'h0;
              l_next.st = ST_SYNC;
            end
          end
          ST_SYNC: begin
            if (!l_reg.sent && !busy) begin
              l_next.sent = 1'b1;
              l_next.req_tgl = ~l_reg.req_tgl;
              l_next.rq = {l_reg.dma, l_reg.wr, l_reg.addr, l_reg.data,
                           l_reg.chan, l_reg.tc, l_reg.bidx};
            end
            if (l_reg.sent && !busy && l_reg.wcnt >= minw) begin
              l_next.err = s_reg.err;
              l_next.lad_out = s_reg.err ? SY_ERR : SY_READY;
              if (!l_reg.wr) begin
                l_next.data = s_reg.rdata;
              end
              l_next.st = l_reg.wr ? ST_DTAR : ST_DDATA;
              l_next.nib = 2'h0;
            end else if (l_reg.wcnt >= smax - 9'h001) begin
              // no answer in time: close the byte with an error
              l_next.err = 1'b1;
              l_next.lad_out = SY_ERR;
              l_next.st = l_reg.wr ? ST_DTAR : ST_DDATA;
              l_next.nib = 2'h0;
            end else begin
              l_next.lad_out = wcode;
              l_next.wcnt = l_reg.wcnt + 9'h001;
            end
          end
          ST_DDATA: begin
            // nibbles go out even after an error sync
            if (l_reg.nib == 2'h0) begin
              l_next.lad_out = l_reg.data[3:0];
              l_next.nib = 2'h1;
            end else begin
              l_next.lad_out = l_reg.data[7:4];
              l_next.nib = 2'h0;
              if (more) begin
                l_next.bidx = l_reg.bidx + 2'h1;
                l_next.wcnt = 9'h000;
                l_next.sent = 1'b0;
                l_next.st = ST_SYNC;
              end else begin
                l_next.st = ST_DTAR;
              end
            end
          end
          ST_DTAR: begin
            unique case (l_reg.nib)
              2'h0: begin
                l_next.lad_out = NIB_TAR;
                l_next.nib = 2'h1;
              end
              2'h1: begin
                l_next.lad_oe = 1'b0;
                l_next.nib = 2'h2;
                if (!more) begin
                  l_next.st = ST_IDLE;
                end
              end
              default: begin
                l_next.bidx = l_reg.bidx + 2'h1;
                l_next.nib = 2'h0;
                l_next.st = ST_HDATA;
              end
            endcase
          end
          default: l_next.st = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge lclk or negedge lrst_n) begin
    if (!lrst_n) begin
      l_reg <= '0;
      l_reg.ldrq_n <= 1'b1;
    end else begin
      l_reg <= l_next;
    end
  end

  // user side: request words are held stable by the toggle handshake
  always_comb begin
    s_next = s_reg;
    s_next.rq_s1 = l_reg.req_tgl;
    s_next.rq_s2 = s_reg.rq_s1;
    s_next.dq_s1 = l_reg.dq_ack;
    s_next.dq_s2 = s_reg.dq_s1;
    // link in reset or re-adopting: its toggle is not a request
    s_next.ad_s1 = l_reg.adopted;
    s_next.ad_s2 = s_reg.ad_s1;
    if (ce) begin
      s_next.rq_s3 = s_reg.rq_s2;
      s_next.req_valid = 1'b0;
      if (s_reg.ad_s2 && (s_reg.rq_s2 != s_reg.rq_s3)) begin
        s_next.req_valid = 1'b1;
        s_next.req = l_reg.rq;
        s_next.pend = 1'b1;
      end else if (s_reg.pend && usr_ack) begin
        s_next.rdata = usr_rdata;
        s_next.err = usr_err;
        s_next.ack_tgl = ~s_reg.ack_tgl;
        s_next.pend = 1'b0;
      end
      if (dma_rq_valid && s_reg.dq_ready) begin
        s_next.dq_chan = dma_rq_chan;
        s_next.dq_act = dma_rq_act;
        s_next.dq_tgl = ~s_reg.dq_tgl;
      end
      s_next.dq_ready = s_next.dq_tgl == s_reg.dq_s2;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.dq_ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  property p_frame_release;
    @(posedge lclk) disable iff (!lrst_n)
    (!cycle_frame_n && l_reg.ce_s2 && l_reg.adopted) |=> !lad_oe;
  endproperty
  a_frame_release: assert property (p_frame_release) else $error("bus held after frame");

  property p_one_wait_code;
    @(posedge lclk) disable iff (!lrst_n)
    (l_reg.st == ST_SYNC && $past(l_reg.st) == ST_SYNC && $past(l_reg.wcnt) != 9'h000)
      |-> lad_out == $past(lad_out);
  endproperty
  a_one_wait_code: assert property (p_one_wait_code) else $error("wait code changed");

  property p_dma_short;
    @(posedge lclk) disable iff (!lrst_n)
    (l_reg.st == ST_SYNC && l_reg.dma && lad_oe && l_reg.wcnt != 9'h000)
      |-> lad_out == SY_SHORT;
  endproperty
  a_dma_short: assert property (p_dma_short) else $error("dma wait not short");

  property p_io_long;
    @(posedge lclk) disable iff (!lrst_n)
    (l_reg.st == ST_SYNC && !l_reg.dma && lad_oe && l_reg.wcnt != 9'h000)
      |-> lad_out == SY_LONG;
  endproperty
  a_io_long: assert property (p_io_long) else $error("io wait not long");

  property p_short_limit;
    @(posedge lclk) disable iff (!lrst_n)
    (lad_oe && lad_out == SY_SHORT)[*7] |=> !(lad_oe && lad_out == SY_SHORT);
  endproperty
  a_short_limit: assert property (p_short_limit) else $error("over eight syncs");

  property p_err_nibbles;
    @(posedge lclk) disable iff (!lrst_n)
    (l_reg.st == ST_DDATA && l_reg.nib == 2'h0 && lad_out == SY_ERR && cycle_frame_n)
      |=> lad_oe ##1 lad_oe;
  endproperty
  a_err_nibbles: assert property (p_err_nibbles) else $error("error read lost data");

  property p_turnaround;
    @(posedge lclk) disable iff (!lrst_n)
    (l_reg.st == ST_DTAR && l_reg.nib == 2'h0 && l_reg.ce_s2 && cycle_frame_n)
      |=> (lad_oe && lad_out == NIB_TAR) ##1 !lad_oe;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("bad device turnaround");

  property p_io_read_waits;
    @(posedge lclk) disable iff (!lrst_n)
    (l_reg.st == ST_DDATA && l_reg.nib == 2'h0 && !l_reg.dma && $changed(l_reg.st))
      |-> $past(lad_out, 1) == SY_LONG && $past(lad_out, 2) == SY_LONG
          && $past(lad_out, 3) == SY_LONG;
  endproperty
  a_io_read_waits: assert property (p_io_read_waits) else $error("io read too fast");

  property p_sync_soon;
    @(posedge lclk) disable iff (!lrst_n)
    (l_reg.st == ST_HTAR && l_reg.nib == 2'h1 && l_reg.ce_s2 && cycle_frame_n)
      |=> lad_oe && lad_out == (l_reg.dma ? SY_SHORT : SY_LONG);
  endproperty
  a_sync_soon: assert property (p_sync_soon) else $error("sync not driven");

endmodule // lpcp_target

// ==== tb/lpcp_host_model.sv ====
// lpcp_host_model: host end of the 4-bit frame bus, runs cycles on request
// assumes the bench resolves the shared nibble with a pull-up to 1111
`timescale 1ns/1ns
module lpcp_host_model
  import lpcp_pkg::*;
(
  input wire logic lclk,
  input wire logic [3:0] lad,
  input wire logic dev_oe,
  input wire logic rq_n,
  output logic frame_n,
  output logic [3:0] lad_h,
  output logic oe
);
  logic found, mix, abo, flt;
  logic [3:0] wcode, sy, turnaround_phase;
  logic [7:0] rd;
  int nwait, idle;
  // frame high and bus released unless a cycle runs
  initial begin
    frame_n = 1'b1;
    lad_h = 4'hf;
    oe = 1'b0;
  end
  task automatic put(input logic [3:0] n, input logic f);
    @(posedge lclk);
    lad_h <= n;
    oe <= 1'b1;
    frame_n <= f;
  endtask
  task automatic nib(output logic [3:0] v);
    @(posedge lclk);
    v = lad;
  endtask
  // one byte per cycle only, wide accesses are the host's to split
  task automatic cyc(input logic [2:0] ct, input logic [15:0] hdr, input logic [7:0] wd,
    input int maxw);
    logic hd;
    logic [3:0] w;
    hd = ct[0] ^ ct[2];
    {found, mix, abo, flt} = 4'h0;
    nwait = 0;
    idle = 0;
    wcode = 4'h0;
    sy = 4'hf;
    turnaround_phase = 4'h0;
    rd = 8'h00;
    put(NIB_START, 1'b0);
    put({ct, 1'b0}, 1'b1);
    for (int i = (ct[2] ? 1 : 3); i >= 0; i--) put(hdr[4*i+:4], 1'b1);
    if (hd) begin
      put(wd[3:0], 1'b1);
      put(wd[7:4], 1'b1);
    end
    put(NIB_TAR, 1'b1);
    @(posedge lclk) oe <= 1'b0;
    while (sy == 4'hf && !abo) begin
      nib(w);
      if (w == SY_SHORT || w == SY_LONG) begin
        mix = mix | (nwait > 0 && w != wcode);
        wcode = w;
        nwait++;
        found = 1'b1;
        abo = (nwait >= maxw);
      end else if (w == 4'hf) begin
        idle++;
        abo = (idle >= 3);
      end else begin
        sy = w;
        found = 1'b1;
      end
    end
    if (abo) begin
      put(4'hf, 1'b0);
      @(posedge lclk) begin
        frame_n <= 1'b1;
        oe <= 1'b0;
      end
    end else begin
      if (!hd) begin
        nib(rd[3:0]);
        nib(rd[7:4]);
      end
      nib(turnaround_phase);
    end
    @(posedge lclk) flt = !dev_oe;
  endtask
  // serial request frame: wait for the start bit, then five samples
  task automatic ldrq(output logic [4:0] bits);
    bits = 5'h1f;
    repeat (40) begin
      @(posedge lclk);
      if (!rq_n) break;
    end
    for (int i = 4; i >= 0; i--) begin
      @(posedge lclk);
      bits[i] = rq_n;
    end
  endtask
endmodule // lpcp_host_model

// ==== tb/tb.sv ====
// tb: self-checking bench of the bus target with a host model and user responder
// assumes lpcp_pkg and lpcp_target compiled first
`timescale 1ns/1ns
module tb
  import lpcp_pkg::*;
;
  `define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
    $display("BAD %0t %h %h", $time, (a), (e)); end end
  typedef struct packed {
    logic [2:0] ct;
    logic [15:0] hdr;
    logic err;
    logic claim;
    logic [7:0] d;
  } lpcp_row_t;
  logic clk, resetn, lclk, bus_reset_n, usr_err, hold;
  logic usr_ack = 1'b0;
  logic pend = 1'b0;
  logic dma_rq_valid, dma_rq_act, lad_oe, hoe, frame_n, dma_request_line_n;
  logic usr_req_valid, dma_rq_ready;
  logic [2:0] dma_rq_chan;
  logic [7:0] usr_rdata;
  logic [3:0] lad_out, hlad, lad_w;
  logic [4:0] bits;
  logic [8:0] mw;
  lpcp_win_t [NWIN-1:0] win;
  lpcp_req_t usr_req;
  lpcp_row_t rows [9];
  int errors, samples_checked;
  assign lad_w = lad_oe ? lad_out : (hoe ? hlad : 4'hf);
  lpcp_target lpcp_target_inst (
    .clk(clk), .resetn(resetn), .ce(1'b1), .lclk(lclk), .bus_reset_n(bus_reset_n),
    .cycle_frame_n(frame_n), .lad_in(lad_w), .lad_out(lad_out), .lad_oe(lad_oe),
    .dma_request_line_n(dma_request_line_n), .win(win), .usr_req_valid(usr_req_valid),
    .usr_req(usr_req), .usr_ack(usr_ack), .usr_rdata(usr_rdata), .usr_err(usr_err),
    .dma_rq_valid(dma_rq_valid), .dma_rq_chan(dma_rq_chan), .dma_rq_act(dma_rq_act),
    .dma_rq_ready(dma_rq_ready)
  );
  lpcp_host_model host (
    .lclk(lclk), .lad(lad_w), .dev_oe(lad_oe), .rq_n(dma_request_line_n),
    .frame_n(frame_n), .lad_h(hlad), .oe(hoe)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // unrelated phase, 125 ns period
  initial begin
    lclk = 1'b0;
    #7;
    forever begin
      #62 lclk = ~lclk;
      #63 lclk = ~lclk;
    end
  end
  // one ack per request; hold stalls it to provoke timeouts and aborts
  always @(posedge clk) begin
    usr_ack <= (pend || usr_req_valid) && !hold && !usr_ack;
    pend <= (pend || usr_req_valid) && (hold || usr_ack);
  end
  task automatic end_sim;
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rq(input logic [2:0] ch, input logic act, input logic [4:0] exp);
    @(posedge clk) begin
      dma_rq_valid <= 1'b1;
      dma_rq_chan <= ch;
      dma_rq_act <= act;
    end
    do @(posedge clk); while (!dma_rq_ready);
    dma_rq_valid <= 1'b0;
    host.ldrq(bits);
    `CHK(bits, exp)
  endtask
  initial begin
    {resetn, bus_reset_n, usr_err, hold, dma_rq_valid, dma_rq_act} = 6'h00;
    dma_rq_chan = 3'h0;
    usr_rdata = 8'h00;
    errors = 0;
    samples_checked = 0;
    win[0] = '{1'b1, 16'h0060, 16'h0004};
    win[1] = '{1'b1, 16'h03f8, 16'h0007};
    win[2] = '{1'b0, 16'h0100, 16'h0000};
    win[3] = '{1'b0, 16'h0000, 16'hffff};
    rows = '{'{CT_IO_RD, 16'h0060, 1'b0, 1'b1, 8'ha5}, '{CT_IO_WR, 16'h03f9, 1'b0, 1'b1, 8'h3c},
      '{CT_IO_RD, 16'h0100, 1'b0, 1'b0, 8'h00}, '{CT_IO_WR, 16'h0061, 1'b0, 1'b0, 8'h00},
      '{3'h2, 16'h0060, 1'b0, 1'b0, 8'h00}, '{CT_DMA_RD, 16'h0020, 1'b0, 1'b1, 8'h96},
      '{CT_DMA_WR, 16'h0010, 1'b0, 1'b1, 8'h69}, '{CT_IO_RD, 16'h0064, 1'b1, 1'b1, 8'h00},
      '{CT_DMA_RD, 16'h0032, 1'b0, 1'b0, 8'h00}};
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (2000) @(posedge clk); // bus clock runs 100 us before release
    bus_reset_n <= 1'b1;
    repeat (20) @(posedge clk);
    foreach (rows[k]) begin
      @(posedge clk) begin
        usr_rdata <= rows[k].d;
        usr_err <= rows[k].err;
      end
      host.cyc(rows[k].ct, rows[k].hdr, rows[k].d, 400);
      `CHK(host.found, rows[k].claim)
      `CHK(host.flt, 1'b1)
      if (rows[k].claim) begin
        mw = rows[k].ct == CT_IO_RD ? WAIT_IO_RD : rows[k].ct == CT_IO_WR ? WAIT_IO_WR :
          rows[k].ct == CT_DMA_RD ? WAIT_DMA_RD : WAIT_DMA_WR;
        `CHK(host.wcode, rows[k].ct[2] ? SY_SHORT : SY_LONG)
        `CHK(host.nwait >= mw, 1'b1)
        `CHK(host.mix, 1'b0)
        `CHK(host.idle <= 2, 1'b1)
        `CHK(host.sy, rows[k].err ? SY_ERR : SY_READY)
        `CHK(host.turnaround_phase, NIB_TAR)
        `CHK(usr_req.wr, rows[k].ct[0] ^ rows[k].ct[2])
        if (rows[k].ct[2]) `CHK(host.nwait < 8, 1'b1)
        `CHK(usr_req.dma, rows[k].ct[2])
        if (rows[k].ct[2]) `CHK(usr_req.tc, rows[k].hdr[7])
        if (rows[k].ct[2]) `CHK(usr_req.bidx, 2'h0)
        if (rows[k].ct[2]) `CHK(usr_req.chan, rows[k].hdr[6:4])
        else `CHK(usr_req.addr, rows[k].hdr)
        if (rows[k].ct[0] ^ rows[k].ct[2]) `CHK(usr_req.wdata, rows[k].d)
        else if (!rows[k].err) `CHK(host.rd, rows[k].d)
      end
    end
    @(posedge clk) hold <= 1'b1;
    host.cyc(CT_IO_WR, 16'h03f8, 8'h11, 2);
    `CHK(host.abo && host.flt, 1'b1)
    @(posedge clk) hold <= 1'b0;
    repeat (10) @(posedge clk);
    hold <= 1'b1;
    host.cyc(CT_IO_RD, 16'h0064, 8'h00, 400);
    `CHK(host.sy, SY_ERR)
    `CHK(host.nwait == 329, 1'b1)
    @(posedge clk) hold <= 1'b0;
    repeat (10) @(posedge clk);
    bus_reset_n <= 1'b0;
    host.cyc(CT_IO_RD, 16'h0060, 8'h00, 400);
    `CHK(host.found, 1'b0)
    `CHK({lad_oe, dma_request_line_n}, 2'b01)
    @(posedge clk) bus_reset_n <= 1'b1;
    repeat (20) @(posedge clk);
    rq(3'h5, 1'b1, 5'b10111);
    rq(3'h2, 1'b0, 5'b01001);
    end_sim;
  end
  // well beyond the longest expected run
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    end_sim;
  end
endmodule // tb
